// *** rtl/dtc_defines.vh ***
// Purpose: Shared constants for the DRAM termination control block.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Register map.
`define DTC_ADDR_W          12
`define DTC_OFF_SETTING     12'h000
`define DTC_OFF_WINDOW      12'h004
`define DTC_OFF_STATUS      12'h008

// Field layout of the termination setting register.
`define DTC_DQ_CODE_MSB     2
`define DTC_DQ_CODE_LSB     0
`define DTC_CA_CODE_MSB     6
`define DTC_CA_CODE_LSB     4
`define DTC_SETTING_W       8
`define DTC_SETTING_RST     8'h00
`define DTC_SETTING_MASK    8'h77

// Write window register.
`define DTC_WINDOW_W        8
`define DTC_WINDOW_ONE      8'h01
`define DTC_WINDOW_ZERO     8'h00

// Status register layout.
`define DTC_ST_STRAP        0
`define DTC_ST_CA_ON        1
`define DTC_ST_WIN_ACTIVE   2
`define DTC_ST_DQ_ON        3
`define DTC_ST_PD           4
`define DTC_ST_SR           5
`define DTC_ST_CA_OHM_MSB   15
`define DTC_ST_CA_OHM_LSB   8
`define DTC_ST_DQ_OHM_MSB   23
`define DTC_ST_DQ_OHM_LSB   16

// Termination codes.
`define DTC_CODE_OFF        3'h0
`define DTC_CODE_240        3'h1
`define DTC_CODE_120        3'h2
`define DTC_CODE_80         3'h3
`define DTC_CODE_60         3'h4
`define DTC_CODE_48         3'h5
`define DTC_CODE_40         3'h6

// Resistance in ohms and reference resistor divisor per code.
`define DTC_OHM_W           8
`define DTC_OHM_NONE        8'h00
`define DTC_OHM_240         8'hf0
`define DTC_OHM_120         8'h78
`define DTC_OHM_80          8'h50
`define DTC_OHM_60          8'h3c
`define DTC_OHM_48          8'h30
`define DTC_OHM_40          8'h28
`define DTC_DIV_NONE        3'h0
`define DTC_DIV_1           3'h1
`define DTC_DIV_2           3'h2
`define DTC_DIV_3           3'h3
`define DTC_DIV_4           3'h4
`define DTC_DIV_5           3'h5
`define DTC_DIV_6           3'h6

// AXI responses.
`define DTC_RESP_OKAY       2'h0
`define DTC_RESP_SLVERR     2'h2
`define DTC_ZERO32          32'h0000_0000

`endif

// *** rtl/dtc_code_decode.v ***
// Purpose: Decode a three-bit termination code into enable and resistance.
// Assumes: Codes above the 40 ohm setting are reserved.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`include "dtc_defines.vh"

module dtc_code_decode
(
  // Code in
  input  wire [2:0] code,
  // Decoded result
  output reg        enable,
  output reg  [7:0] resistance_ohm,
  output reg  [2:0] reference_divisor
);

  always @*
  begin
    enable            = 1'b1;
    resistance_ohm    = `DTC_OHM_NONE;
    reference_divisor = `DTC_DIV_NONE;
    case (code)
      `DTC_CODE_240:
      begin
        resistance_ohm    = `DTC_OHM_240; // [R6]
        reference_divisor = `DTC_DIV_1;
      end
      `DTC_CODE_120:
      begin
        resistance_ohm    = `DTC_OHM_120; // [R6]
        reference_divisor = `DTC_DIV_2;
      end
      `DTC_CODE_80:
      begin
        resistance_ohm    = `DTC_OHM_80; // [R6]
        reference_divisor = `DTC_DIV_3;
      end
      `DTC_CODE_60:
      begin
        resistance_ohm    = `DTC_OHM_60; // [R6]
        reference_divisor = `DTC_DIV_4;
      end
      `DTC_CODE_48:
      begin
        resistance_ohm    = `DTC_OHM_48; // [R6]
        reference_divisor = `DTC_DIV_5;
      end
      `DTC_CODE_40:
      begin
        resistance_ohm    = `DTC_OHM_40; // [R6]
        reference_divisor = `DTC_DIV_6;
      end
      // The all-zero code and the reserved code both mean no termination.
      default:
      begin
        enable = 1'b0; // [R4] [R11]
      end
    endcase
  end

endmodule // dtc_code_decode

// *** rtl/dtc_top.v ***
// Purpose: Termination control for command/address and data-side pins of a DRAM.
// Assumes: Power state and write commands come from logic on aclk; the strap is a pin.
// Notes:   Registers sit behind an AXI4-Lite slave; unmapped addresses give SLVERR.
`timescale 1ns/1ps
`include "dtc_defines.vh"

// Overview of operation
// R1: Data termination off in power-down or self-refresh.
// R2: Write or masked-write command turns data termination on.
// R3: Non-zero data field enables and selects resistance.
// R4: All-zero data field disables data termination.
// R5: Power-down leaves command/address strap state unchanged.
// R6: CA codes map 240 down to 40 ohm.
// R7: Per-line enables for data, strobes and mask.
// R8: CA termination disabled after reset until programmed.
// R9: Strap low forbids CA termination; high uses field.
// R10: Data termination turns off after write burst.
// R11: Controller writes only codes zero through six.
module dtc_top #
(
  parameter DQ_WIDTH       = 16,
  parameter WINDOW_DEFAULT = 8
)
(
  // Clock, reset and enable
  input  wire                  aclk,
  input  wire                  aresetn,
  input  wire                  clk_en,
  // AXI4-Lite write address
  input  wire [11:0]           s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]           s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Device state and commands
  input  wire                  ca_termination_strap,
  input  wire                  power_down,
  input  wire                  self_refresh,
  input  wire                  write_cmd,
  input  wire                  masked_write_cmd,
  // Command/address termination
  output reg                   ca_term_en,
  output reg  [7:0]            ca_termination_resistance,
  output reg  [2:0]            ca_reference_divisor,
  // Data-side termination
  output reg  [DQ_WIDTH-1:0]   dq_term_en,
  output reg                   dqs_t_term_en,
  output reg                   dqs_c_term_en,
  output reg                   dmi_term_en,
  output reg  [7:0]            dq_termination_resistance,
  output reg  [2:0]            dq_reference_divisor
);

  localparam [31:0]            WINDOW_INIT = WINDOW_DEFAULT;
  // Register state
  reg  [7:0]                   termination_setting_reg;
  reg  [7:0]                   window_len_reg;
  reg  [7:0]                   window_cnt_reg;
  reg  [7:0]                   window_cnt_next;
  reg                          strap_meta_reg;
  reg                          strap_sync_reg;

  // Bus slave state
  reg                          aw_full_reg;
  reg  [11:0]                  aw_addr_reg;
  reg                          w_full_reg;
  reg  [31:0]                  w_data_reg;
  reg  [3:0]                   w_strb_reg;
  reg  [31:0]                  rd_word;
  reg                          rd_ok;

  // Decoded codes
  wire                         ca_code_en;
  wire [7:0]                   ca_ohm;
  wire [2:0]                   ca_div;
  wire                         dq_code_en;
  wire [7:0]                   dq_ohm;
  wire [2:0]                   dq_div;
  wire                         low_power;
  wire                         any_write;
  wire                         window_active;
  wire                         dq_on_next;
  wire                         ca_on_next;
  wire                         do_write;
  wire [31:0]                  status_word;

  dtc_code_decode u_ca_decode
  (
    .code              (termination_setting_reg[`DTC_CA_CODE_MSB:`DTC_CA_CODE_LSB]),
    .enable            (ca_code_en),
    .resistance_ohm    (ca_ohm),
    .reference_divisor (ca_div)
  );

  dtc_code_decode u_dq_decode
  (
    .code              (termination_setting_reg[`DTC_DQ_CODE_MSB:`DTC_DQ_CODE_LSB]),
    .enable            (dq_code_en),
    .resistance_ohm    (dq_ohm),
    .reference_divisor (dq_div)
  );

  assign low_power = power_down | self_refresh;
  assign any_write = write_cmd | masked_write_cmd;

  // The strap pin is brought onto aclk before anything looks at it.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_meta_reg <= ca_termination_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // A write command loads the window, a later one extends it, and low power cancels it.
  always @*
  begin
    window_cnt_next = window_cnt_reg;
    if (any_write && dq_code_en && !low_power) // [R2] [R3]
    begin
      if (window_len_reg == `DTC_WINDOW_ZERO)
      begin
        window_cnt_next = `DTC_WINDOW_ONE;
      end
      else
      begin
        window_cnt_next = window_len_reg;
      end
    end
    else if (window_cnt_reg != `DTC_WINDOW_ZERO)
    begin
      window_cnt_next = low_power ? `DTC_WINDOW_ZERO
                                  : window_cnt_reg - `DTC_WINDOW_ONE; // [R1] [R10]
    end
  end

  assign window_active = (window_cnt_next != `DTC_WINDOW_ZERO);
  // Data termination needs an enabled code, an open window and full power.
  assign dq_on_next = window_active && dq_code_en && !low_power; // [R1] [R3] [R4] [R10]
  // The power state has no say here so other ranks stay terminated.
  assign ca_on_next = strap_sync_reg && ca_code_en; // [R5] [R9]

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      window_cnt_reg            <= `DTC_WINDOW_ZERO;
      ca_term_en                <= 1'b0;
      ca_termination_resistance <= `DTC_OHM_NONE;
      ca_reference_divisor      <= `DTC_DIV_NONE;
      dqs_t_term_en             <= 1'b0;
      dqs_c_term_en             <= 1'b0;
      dmi_term_en               <= 1'b0;
      dq_termination_resistance <= `DTC_OHM_NONE;
      dq_reference_divisor      <= `DTC_DIV_NONE;
    end
    else if (clk_en)
    begin
      window_cnt_reg            <= window_cnt_next;
      ca_term_en                <= ca_on_next; // [R9]
      ca_termination_resistance <= ca_on_next ? ca_ohm : `DTC_OHM_NONE; // [R6] [R9]
      ca_reference_divisor      <= ca_on_next ? ca_div : `DTC_DIV_NONE;
      dqs_t_term_en             <= dq_on_next; // [R7]
      dqs_c_term_en             <= dq_on_next; // [R7]
      dmi_term_en               <= dq_on_next; // [R7]
      dq_termination_resistance <= dq_on_next ? dq_ohm : `DTC_OHM_NONE; // [R3]
      dq_reference_divisor      <= dq_on_next ? dq_div : `DTC_DIV_NONE;
    end
  end

  // Each data line has its own termination switch.
  genvar i;
  generate
    for (i = 0; i < DQ_WIDTH; i = i + 1)
    begin : g_dq_line
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          dq_term_en[i] <= 1'b0;
        end
        else if (clk_en)
        begin
          dq_term_en[i] <= dq_on_next; // [R7] [R1]
        end
      end
    end
  endgenerate

  // Write channels are taken independently and held until both are present.
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg             <= 1'b0;
      aw_addr_reg             <= 12'h000;
      w_full_reg              <= 1'b0;
      w_data_reg              <= `DTC_ZERO32;
      w_strb_reg              <= 4'h0;
      s_axi_bvalid            <= 1'b0;
      s_axi_bresp             <= `DTC_RESP_OKAY;
      termination_setting_reg <= `DTC_SETTING_RST; // [R8]
      window_len_reg          <= WINDOW_INIT[7:0];
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DTC_RESP_OKAY;
        case (aw_addr_reg)
          `DTC_OFF_SETTING:
          begin
            if (w_strb_reg[0])
            begin
              termination_setting_reg <= w_data_reg[7:0] & `DTC_SETTING_MASK;
            end
          end
          `DTC_OFF_WINDOW:
          begin
            if (w_strb_reg[0])
            begin
              window_len_reg <= w_data_reg[7:0];
            end
          end
          `DTC_OFF_STATUS:
          begin
            s_axi_bresp <= `DTC_RESP_OKAY;
          end
          default:
          begin
            s_axi_bresp <= `DTC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign status_word = {8'h00, dq_termination_resistance, ca_termination_resistance, 2'h0,
                        self_refresh, power_down, dqs_t_term_en,
                        (window_cnt_reg != `DTC_WINDOW_ZERO), ca_term_en, strap_sync_reg};

  // Read data mux with an error answer for unmapped words.
  always @*
  begin
    rd_word = `DTC_ZERO32;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `DTC_OFF_SETTING:
      begin
        rd_word = {24'h000000, termination_setting_reg};
      end
      `DTC_OFF_WINDOW:
      begin
        rd_word = {24'h000000, window_len_reg};
      end
      `DTC_OFF_STATUS:
      begin
        rd_word = status_word;
      end
      default:
      begin
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `DTC_ZERO32;
      s_axi_rresp  <= `DTC_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // dtc_top

// *** test/dtc_chk.sv ***
// Purpose: Concurrent checks on the termination outputs of the top module.
// Assumes: The write window stays at its reset length of 8 cycles.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/1ps
module dtc_chk #
(
  parameter DQ_WIDTH       = 16,
  parameter WINDOW_DEFAULT = 8
)
(
  // Clock and reset
  input logic                aclk,
  input logic                aresetn,
  // Device state, commands and bus
  input logic                power_down,
  input logic                self_refresh,
  input logic                write_cmd,
  input logic                masked_write_cmd,
  input logic                ca_termination_strap,
  input logic                s_axi_bvalid,
  // Termination outputs
  input logic                ca_term_en,
  input logic [7:0]          ca_termination_resistance,
  input logic [2:0]          ca_reference_divisor,
  input logic [DQ_WIDTH-1:0] dq_term_en,
  input logic                dqs_t_term_en,
  input logic                dqs_c_term_en,
  input logic                dmi_term_en,
  input logic [7:0]          dq_termination_resistance
);
  wire cmd = write_cmd | masked_write_cmd;
  wire lp  = power_down | self_refresh;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_lp_off; lp |=> !dqs_t_term_en; endproperty
  a_lp_off: assert property (p_lp_off) else $error("data termination on in low power");
  property p_on_cmd; $rose(dqs_t_term_en) |-> $past(cmd) && !$past(lp); endproperty
  a_on_cmd: assert property (p_on_cmd) else $error("data termination without command");
  property p_dq_ohm; dqs_t_term_en == (dq_termination_resistance != 8'h00); endproperty
  a_dq_ohm: assert property (p_dq_ohm) else $error("data resistance and enable disagree");
  property p_lines;
    dq_term_en == {DQ_WIDTH{dqs_t_term_en}} && dqs_c_term_en == dqs_t_term_en
      && dmi_term_en == dqs_t_term_en;
  endproperty
  a_lines: assert property (p_lines) else $error("data line enables differ");
  property p_ca_keep; power_down && ca_term_en && !s_axi_bvalid |=> ca_term_en; endproperty
  a_ca_keep: assert property (p_ca_keep) else $error("CA termination lost in power-down");
  property p_ca_map;
    ca_term_en |-> {3'h0, ca_termination_resistance} * {8'h00, ca_reference_divisor} == 11'h0f0;
  endproperty
  a_ca_map: assert property (p_ca_map) else $error("CA resistance and divisor mismatch");
  property p_ca_off;
    !ca_term_en |-> ca_termination_resistance == 8'h00 && ca_reference_divisor == 3'h0;
  endproperty
  a_ca_off: assert property (p_ca_off) else $error("CA resistance while disabled");
  property p_strap; !ca_termination_strap [*3] |=> !ca_term_en; endproperty
  a_strap: assert property (p_strap) else $error("CA termination with strap low");
  property p_window;
    $rose(dqs_t_term_en) ##0 (!cmd && !lp) [*8] |-> dqs_t_term_en ##1 !dqs_t_term_en;
  endproperty
  a_window: assert property (p_window) else $error("data termination window length wrong");

  c_window: cover property ($fell(dqs_t_term_en));
  c_ca_pd: cover property (power_down && ca_term_en);
  c_strap: cover property ($fell(ca_term_en));
endmodule // dtc_chk

// *** test/dtc_ctrl_model.sv ***
// Purpose: Memory controller side: write commands and power state.
// Assumes: Commands are single-cycle pulses on the device clock.
// Notes:   The bench calls the tasks; signals change just after an edge.
`timescale 1ns/1ps
module dtc_ctrl_model
(
  // Clock
  input  logic aclk,
  // Commands and power state toward the device
  output logic write_cmd,
  output logic masked_write_cmd,
  output logic power_down,
  output logic self_refresh
);
  initial
  begin
    write_cmd = 1'h0;
    masked_write_cmd = 1'h0;
    power_down = 1'h0;
    self_refresh = 1'h0;
  end

  // One sampled write or masked write, held for exactly one cycle.
  task automatic cmd(input logic masked);
    @(posedge aclk);
    write_cmd <= !masked;
    masked_write_cmd <= masked;
    @(posedge aclk);
    write_cmd <= 1'h0;
    masked_write_cmd <= 1'h0;
  endtask

  task automatic pwr(input logic pd, input logic sr);
    @(posedge aclk);
    power_down <= pd;
    self_refresh <= sr;
  endtask
endmodule // dtc_ctrl_model

// *** test/dtc_top_tb.sv ***
// Purpose: Self-checking bench for the termination control top.
// Assumes: Window length 8; status word shows the termination state.
// Notes:   Results are checked by a monitor against a queue of notes.
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_top_tb;
  typedef struct {string nm; logic [33:0] v;} dtc_note_t;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        ca_termination_strap = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        clk_en = 1'h1;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        write_cmd, masked_write_cmd, power_down, self_refresh;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         ca_term_en, dqs_t_term_en, dqs_c_term_en, dmi_term_en;
  wire  [7:0]  ca_termination_resistance, dq_termination_resistance;
  wire  [2:0]  ca_reference_divisor, dq_reference_divisor;
  wire  [15:0] dq_term_en;
  int          errors = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h6;
  dtc_note_t   q[$];
  logic [7:0]  ohm_t [8] = '{8'h00, 8'hf0, 8'h78, 8'h50, 8'h3c, 8'h30, 8'h28, 8'h00};

  always #2.5 aclk = ~aclk;

  dtc_top #(.DQ_WIDTH(16), .WINDOW_DEFAULT(8)) DUT
  (
    .aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ca_termination_strap, .power_down, .self_refresh, .write_cmd, .masked_write_cmd,
    .ca_term_en, .ca_termination_resistance, .ca_reference_divisor,
    .dq_term_en, .dqs_t_term_en, .dqs_c_term_en, .dmi_term_en,
    .dq_termination_resistance, .dq_reference_divisor
  );

  dtc_ctrl_model u_ctrl (.aclk, .write_cmd, .masked_write_cmd, .power_down, .self_refresh);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected status word: ohms, power state, data on, window, CA on, strap.
  function automatic logic [31:0] st(logic s, logic [2:0] ca, dq, logic w, on, pd, sr);
    return {8'h00, on ? ohm_t[dq] : 8'h00, s ? ohm_t[ca] : 8'h00, 2'h0, sr, pd, on, w,
            s && ca != 3'h0, s};
  endfunction

  task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r);
    q.push_back('{"write response", {r, 32'h0}});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(string nm, logic [11:0] a, logic [33:0] e);
    q.push_back('{nm, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  task automatic note(logic [33:0] v);
    dtc_note_t n;
    n = '{"empty queue", ~v};
    if (q.size() > 0) n = q.pop_front();
    chk(n.nm, v, n.v);
  endtask

  always @(posedge aclk)
  begin
    if (aresetn && s_axi_bvalid && s_axi_bready) note({s_axi_bresp, 32'h0});
    if (aresetn && s_axi_rvalid && s_axi_rready) note({s_axi_rresp, s_axi_rdata});
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    logic [2:0]  c;
    logic [31:0] d;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd("setting", `DTC_OFF_SETTING, 34'h0);
    rd("window", `DTC_OFF_WINDOW, 34'h8);
    rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, 3'h0, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0)});
    rd("unmapped", 12'h00c, {2'h2, 32'h0});
    wr(12'h00c, 32'h1, 2'h2);
    wr(`DTC_OFF_STATUS, 32'h0, 2'h0);
    for (c = 3'h0; c < 3'h7; c++)
    begin
      d = (xs() & ~32'h77) | {25'h0, c, 4'h0};
      wr(`DTC_OFF_SETTING, d, 2'h0);
      rd("setting", `DTC_OFF_SETTING, {2'h0, d & 32'h77});
      rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, c, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0)});
    end
    // A write with byte lane 0 off must leave the setting alone.
    s_axi_wstrb <= 4'he;
    wr(`DTC_OFF_SETTING, 32'h11, 2'h0);
    rd("setting", `DTC_OFF_SETTING, 34'h60);
    s_axi_wstrb <= 4'hf;
    ca_termination_strap <= 1'h0;
    repeat (4) @(posedge aclk);
    rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h0, 3'h6, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0)});
    ca_termination_strap <= 1'h1;
    repeat (4) @(posedge aclk);
    for (c = 3'h0; c < 3'h7; c++)
    begin
      wr(`DTC_OFF_SETTING, {25'h0, 3'h2, 1'h0, c}, 2'h0);
      u_ctrl.cmd(c[0]);
      rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, 3'h2, c, c != 3'h0, c != 3'h0, 1'h0, 1'h0)});
      q.push_back('{"data lines", {13'h0, c, {18{c != 3'h0}}}});
      #1;
      note({13'h0, dq_reference_divisor, dmi_term_en, dqs_c_term_en, dq_term_en});
      repeat (10) @(posedge aclk);
      rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, 3'h2, c, 1'h0, 1'h0, 1'h0, 1'h0)});
    end
    // A command while the clock enable is low must not open a window.
    clk_en <= 1'h0;
    u_ctrl.cmd(1'h0);
    clk_en <= 1'h1;
    rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, 3'h2, 3'h6, 1'h0, 1'h0, 1'h0, 1'h0)});
    u_ctrl.pwr(1'h1, 1'h0);
    u_ctrl.cmd(1'h0);
    rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, 3'h2, 3'h6, 1'h0, 1'h0, 1'h1, 1'h0)});
    u_ctrl.pwr(1'h0, 1'h1);
    u_ctrl.cmd(1'h1);
    rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, 3'h2, 3'h6, 1'h0, 1'h0, 1'h0, 1'h1)});
    u_ctrl.pwr(1'h0, 1'h0);
    u_ctrl.cmd(1'h0);
    u_ctrl.pwr(1'h1, 1'h0);
    rd("status", `DTC_OFF_STATUS, {2'h0, st(1'h1, 3'h2, 3'h6, 1'h0, 1'h0, 1'h1, 1'h0)});
    u_ctrl.pwr(1'h0, 1'h0);
    repeat (10) @(posedge aclk);
    tally_and_finish();
  end
endmodule // dtc_top_tb

bind dtc_top dtc_chk #(.DQ_WIDTH(DQ_WIDTH), .WINDOW_DEFAULT(WINDOW_DEFAULT)) u_chk
(
  .aclk, .aresetn, .power_down, .self_refresh, .write_cmd, .masked_write_cmd,
  .ca_termination_strap, .s_axi_bvalid, .ca_term_en, .ca_termination_resistance,
  .ca_reference_divisor, .dq_term_en, .dqs_t_term_en, .dqs_c_term_en, .dmi_term_en,
  .dq_termination_resistance
);
